// ### slc_consts.svh
`ifndef SLC_CONSTS_SVH
`define SLC_CONSTS_SVH
`define SLC_ADDR_ENABLE   12'h200
`define SLC_ADDR_MODE     12'h201
`define SLC_ADDR_KM       12'h202
`define SLC_ADDR_SYNC     12'h203
`define SLC_ADDR_CTRL     12'h204
`define SLC_ADDR_TEST     12'h205
`define SLC_RST_ENABLE    8'h01
`define SLC_RST_MODE      8'h00
`define SLC_RST_KM        8'h1F
`define SLC_RST_SYNC      8'h01
`define SLC_RST_CTRL      8'h03
`define SLC_RST_TEST      8'h00
`define SLC_BIT_SCR       0
`define SLC_BIT_FMT       1
`define SLC_SEL_LO        2
`define SLC_SEL_HI        3
`define SLC_BIT_UPPER     4
`define SLC_SEL_SE        2'h0
`define SLC_SEL_TS        2'h1
`define SLC_SEL_NONE      2'h2
`define SLC_MODE_LSB_66   5
`define SLC_LANE_SHIFT    3'h4
`define SLC_K_SCALE       10'h100
`define SLC_FIELD_CTRL_W  5
`define SLC_FIELD_TEST_W  5
`define SLC_FIELD_MODE_W  6
`endif

// ### slc_pkg.sv
package slc_pkg;
	typedef struct packed {
		logic [11:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} slc_bus_t;

	typedef struct packed {
		logic       link_enable;
		logic [7:0] k_minus_one;
		logic       sync_request;
		logic [7:0] lane_mask;
		logic       sample_format;
		logic       scramble;
		logic [4:0] test_select;
		logic [5:0] mode;
	} slc_link_cfg_t;
endpackage : slc_pkg

// ### slc_sync2.sv
`timescale 1ns/10ps
module slc_sync2 (
	input  wire logic ref_clk,
	input  wire logic reset,
	input  wire logic din,
	output logic      dout
);
	logic meta_r;

	// Pins idle high (no request) so reset to one
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			meta_r <= 1'b1;
			dout   <= 1'b1;
		end else begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end
endmodule : slc_sync2

// ### slc_regs.sv
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`include "slc_consts.svh"
module slc_regs (
	input  wire logic                   ref_clk,
	input  wire logic                   reset,
	input  wire slc_pkg::slc_bus_t      bus,
	output logic [7:0]                  rdata,
	input  wire logic                   single_ended_sync_input_n,
	input  wire logic                   differential_timestamp_input_n,
	input  wire logic [1:0]             e_param,
	input  wire logic [7:0]             f_param,
	input  wire logic [3:0]             lane_count,
	output slc_pkg::slc_link_cfg_t      link_cfg,
	output logic [7:0]                  k_effective,
	output logic                        link_reset,
	output logic                        serializer_power_down
);
	import slc_pkg::*;

	logic [7:0] serial_link_enable_r;
	logic [7:0] output_mode_select_r;
	logic [7:0] frames_per_multiframe_minus_one_r;
	logic [7:0] software_sync_request_r;
	logic [7:0] link_control_r;
	logic [7:0] link_test_select_r;
	logic       se_sync_n;
	logic       ts_sync_n;
	logic [1:0] sync_source;
	logic       pin_request;
	logic       sync_request_nxt;
	logic       mode_66;
	logic [9:0] k_scaled;
	logic [7:0] k_nxt;
	logic [7:0] lane_mask_nxt;
	logic [7:0] lane_base;

	// Sync pins come from the receiver's domain
	slc_sync2 u_sync_se (
		.ref_clk(ref_clk),
		.reset  (reset),
		.din    (single_ended_sync_input_n),
		.dout   (se_sync_n)
	);

	slc_sync2 u_sync_ts (
		.ref_clk(ref_clk),
		.reset  (reset),
		.din    (differential_timestamp_input_n),
		.dout   (ts_sync_n)
	);

	// Register writes; all bits stored so readback matches
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			serial_link_enable_r              <= `SLC_RST_ENABLE;
			output_mode_select_r              <= `SLC_RST_MODE;
			frames_per_multiframe_minus_one_r <= `SLC_RST_KM;
			software_sync_request_r           <= `SLC_RST_SYNC;
			link_control_r                    <= `SLC_RST_CTRL;
			link_test_select_r                <= `SLC_RST_TEST;
		end else if (bus.wr) begin
			case (bus.addr)
				`SLC_ADDR_ENABLE: serial_link_enable_r              <= bus.wdata;
				`SLC_ADDR_MODE:   output_mode_select_r              <= bus.wdata;
				`SLC_ADDR_KM:     frames_per_multiframe_minus_one_r <= bus.wdata;
				`SLC_ADDR_SYNC:   software_sync_request_r           <= bus.wdata;
				`SLC_ADDR_CTRL:   link_control_r                    <= bus.wdata;
				`SLC_ADDR_TEST:   link_test_select_r                <= bus.wdata;
				default: begin
				end
			endcase
		end
	end

	// Read data valid the cycle after the strobe; unmapped reads zero
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			rdata <= 8'h00;
		end else if (bus.rd) begin
			case (bus.addr)
				`SLC_ADDR_ENABLE: rdata <= serial_link_enable_r;
				`SLC_ADDR_MODE:   rdata <= output_mode_select_r;
				`SLC_ADDR_KM:     rdata <= frames_per_multiframe_minus_one_r;
				`SLC_ADDR_SYNC:   rdata <= software_sync_request_r;
				`SLC_ADDR_CTRL:   rdata <= link_control_r;
				`SLC_ADDR_TEST:   rdata <= link_test_select_r;
				default:          rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	assign sync_source = link_control_r[`SLC_SEL_HI:`SLC_SEL_LO];
	assign mode_66     = output_mode_select_r[`SLC_MODE_LSB_66];

	// Pin request is active low; code 3 treated like code 2
	always_comb begin
		case (sync_source)
			`SLC_SEL_SE: pin_request = ~se_sync_n;
			`SLC_SEL_TS: pin_request = ~ts_sync_n;
			default:     pin_request = 1'b0;
		endcase
	end

	// Software request ORed in under every source
	assign sync_request_nxt = pin_request | ~software_sync_request_r[0];

	// K for 64B/66B is 256*E/F; F of zero would divide by zero, so fall back
	assign k_scaled = `SLC_K_SCALE * {8'h00, e_param};
	always_comb begin
		if (mode_66 && (f_param != 8'h00)) begin
			k_nxt = 8'((k_scaled / {2'h0, f_param}) - 10'h001);
		end else begin
			k_nxt = frames_per_multiframe_minus_one_r;
		end
	end

	// Upper mapping shifts the lane window by four
	assign lane_base = link_control_r[`SLC_BIT_UPPER] ? {5'h00, `SLC_LANE_SHIFT} : 8'h00;
	always_comb begin
		lane_mask_nxt = 8'((9'h001 << lane_count) - 9'h001);
		lane_mask_nxt = 8'(lane_mask_nxt << lane_base);
	end

	// Outputs registered; disabled link holds link reset and power down and clears the lane mask
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			link_cfg              <= '0;
			k_effective           <= `SLC_RST_KM;
			link_reset            <= 1'b1;
			serializer_power_down <= 1'b1;
		end else begin
			link_reset            <= ~serial_link_enable_r[0];
			serializer_power_down <= ~serial_link_enable_r[0];
			k_effective           <= k_nxt;
			link_cfg.link_enable  <= serial_link_enable_r[0];
			link_cfg.k_minus_one  <= k_nxt;
			link_cfg.sync_request <= sync_request_nxt;
			link_cfg.lane_mask    <= serial_link_enable_r[0] ? lane_mask_nxt : 8'h00;
			link_cfg.sample_format <= link_control_r[`SLC_BIT_FMT];
			link_cfg.scramble     <= mode_66 | link_control_r[`SLC_BIT_SCR];
			link_cfg.test_select  <= link_test_select_r[`SLC_FIELD_TEST_W-1:0];
			link_cfg.mode         <= output_mode_select_r[`SLC_FIELD_MODE_W-1:0];
		end
	end

	a_sw_sync_req: assert property (@(posedge ref_clk) disable iff (reset)
		!software_sync_request_r[0] |=> link_cfg.sync_request)
		else $error("software sync request not asserted");

	a_pin_hold_req: assert property (@(posedge ref_clk) disable iff (reset)
		(sync_source == `SLC_SEL_SE && !se_sync_n) |=> link_cfg.sync_request)
		else $error("held pin did not keep request");

	a_none_release: assert property (@(posedge ref_clk) disable iff (reset)
		(sync_source == `SLC_SEL_NONE && software_sync_request_r[0]) |=> !link_cfg.sync_request)
		else $error("request not released with no pin");

	a_scr_66_force: assert property (@(posedge ref_clk) disable iff (reset)
		mode_66 |=> link_cfg.scramble)
		else $error("64b66b mode not scrambled");

	a_scr_follow: assert property (@(posedge ref_clk) disable iff (reset)
		!mode_66 |=> link_cfg.scramble == $past(link_control_r[`SLC_BIT_SCR]))
		else $error("scrambler enable not followed");

	a_fmt_follow: assert property (@(posedge ref_clk) disable iff (reset)
		1'b1 |=> link_cfg.sample_format == $past(link_control_r[`SLC_BIT_FMT]))
		else $error("sample format mismatch");

	a_k_legacy: assert property (@(posedge ref_clk) disable iff (reset)
		!mode_66 |=> k_effective == $past(frames_per_multiframe_minus_one_r))
		else $error("K minus one not taken from register");

	a_disable_hold: assert property (@(posedge ref_clk) disable iff (reset)
		!serial_link_enable_r[0] |=> (link_reset && serializer_power_down && link_cfg.lane_mask == 8'h00))
		else $error("link not held while disabled");

	sequence s_write_km;
		bus.wr && bus.addr == `SLC_ADDR_KM;
	endsequence

	a_km_readback: assert property (@(posedge ref_clk) disable iff (reset)
		s_write_km ##1 (bus.rd && bus.addr == `SLC_ADDR_KM) |=> rdata == $past(bus.wdata, 2))
		else $error("readback mismatch");

	a_upper_lanes: assert property (@(posedge ref_clk) disable iff (reset)
		(serial_link_enable_r[0] && link_control_r[`SLC_BIT_UPPER] && lane_count <= 4'h4)
		|=> link_cfg.lane_mask[3:0] == 4'h0)
		else $error("upper mapping used low lanes");

	a_upper_four: assert property (@(posedge ref_clk) disable iff (reset)
		(serial_link_enable_r[0] && link_control_r[`SLC_BIT_UPPER] && lane_count == 4'h4)
		|=> link_cfg.lane_mask == 8'hF0)
		else $error("upper mapping lane window wrong");

	a_lower_four: assert property (@(posedge ref_clk) disable iff (reset)
		(serial_link_enable_r[0] && !link_control_r[`SLC_BIT_UPPER] && lane_count == 4'h4)
		|=> link_cfg.lane_mask == 8'h0F)
		else $error("normal mapping lane window wrong");

	a_lower_lanes: assert property (@(posedge ref_clk) disable iff (reset)
		(serial_link_enable_r[0] && !link_control_r[`SLC_BIT_UPPER] && lane_count <= 4'h4)
		|=> link_cfg.lane_mask[7:4] == 4'h0)
		else $error("normal mapping used high lanes");

	a_ts_hold_req: assert property (@(posedge ref_clk) disable iff (reset)
		(sync_source == `SLC_SEL_TS && !ts_sync_n)
		|=> link_cfg.sync_request)
		else $error("held timestamp pin did not keep request");

	a_none_pin_free: assert property (@(posedge ref_clk) disable iff (reset)
		(sync_source == `SLC_SEL_NONE)
		|=> link_cfg.sync_request == $past(!software_sync_request_r[0]))
		else $error("pin leaked into request with no pin selected");

	a_se_release: assert property (@(posedge ref_clk) disable iff (reset)
		(sync_source == `SLC_SEL_SE && se_sync_n && software_sync_request_r[0])
		|=> !link_cfg.sync_request)
		else $error("idle single ended pin still requests");

	a_ts_release: assert property (@(posedge ref_clk) disable iff (reset)
		(sync_source == `SLC_SEL_TS && ts_sync_n && software_sync_request_r[0])
		|=> !link_cfg.sync_request)
		else $error("idle timestamp pin still requests");

	// Write of zero to the sync bit shows on the request two edges on
	sequence s_sw_sync_clear;
		bus.wr && bus.addr == `SLC_ADDR_SYNC && !bus.wdata[0];
	endsequence

	a_sw_sync_walk: assert property (@(posedge ref_clk) disable iff (reset)
		s_sw_sync_clear
		|=> ##1 link_cfg.sync_request)
		else $error("sync write did not raise request in time");

	sequence s_write_disable;
		bus.wr && bus.addr == `SLC_ADDR_ENABLE && !bus.wdata[0];
	endsequence

	a_disable_walk: assert property (@(posedge ref_clk) disable iff (reset)
		s_write_disable
		|=> ##1 (link_reset && serializer_power_down))
		else $error("disable write did not hold link in time");

	a_enabled_run: assert property (@(posedge ref_clk) disable iff (reset)
		serial_link_enable_r[0]
		|=> (!link_reset && !serializer_power_down))
		else $error("enabled link still held");

	a_enable_follow: assert property (@(posedge ref_clk) disable iff (reset)
		1'b1
		|=> link_cfg.link_enable == $past(serial_link_enable_r[0]))
		else $error("link enable not forwarded");

	a_k_66: assert property (@(posedge ref_clk) disable iff (reset)
		(mode_66 && f_param != 8'h00)
		|=> k_effective == 8'(((16'h0100 * {14'h0000, $past(e_param)}) / {8'h00, $past(f_param)}) - 16'h0001))
		else $error("64b66b K not derived from E and F");

	a_k_cfg_match: assert property (@(posedge ref_clk) disable iff (reset)
		1'b1
		|=> link_cfg.k_minus_one == k_effective)
		else $error("K in link settings differs");

	a_mode_follow: assert property (@(posedge ref_clk) disable iff (reset)
		1'b1
		|=> link_cfg.mode == $past(output_mode_select_r[`SLC_FIELD_MODE_W-1:0]))
		else $error("mode not forwarded");

	a_test_follow: assert property (@(posedge ref_clk) disable iff (reset)
		1'b1
		|=> link_cfg.test_select == $past(link_test_select_r[`SLC_FIELD_TEST_W-1:0]))
		else $error("test select not forwarded");

	a_rdata_idle: assert property (@(posedge ref_clk) disable iff (reset)
		!bus.rd
		|=> rdata == 8'h00)
		else $error("read data left standing");

	a_unmapped_rd: assert property (@(posedge ref_clk) disable iff (reset)
		(bus.rd && (bus.addr < `SLC_ADDR_ENABLE || bus.addr > `SLC_ADDR_TEST))
		|=> rdata == 8'h00)
		else $error("unmapped read not zero");

	a_enable_rb: assert property (@(posedge ref_clk) disable iff (reset)
		(bus.rd && bus.addr == `SLC_ADDR_ENABLE)
		|=> rdata == $past(serial_link_enable_r))
		else $error("enable readback wrong");

	a_mode_rb: assert property (@(posedge ref_clk) disable iff (reset)
		(bus.rd && bus.addr == `SLC_ADDR_MODE)
		|=> rdata == $past(output_mode_select_r))
		else $error("mode readback wrong");

	a_sync_rb: assert property (@(posedge ref_clk) disable iff (reset)
		(bus.rd && bus.addr == `SLC_ADDR_SYNC)
		|=> rdata == $past(software_sync_request_r))
		else $error("sync readback wrong");

	a_ctrl_rb: assert property (@(posedge ref_clk) disable iff (reset)
		(bus.rd && bus.addr == `SLC_ADDR_CTRL)
		|=> rdata == $past(link_control_r))
		else $error("control readback wrong");

	a_test_rb: assert property (@(posedge ref_clk) disable iff (reset)
		(bus.rd && bus.addr == `SLC_ADDR_TEST)
		|=> rdata == $past(link_test_select_r))
		else $error("test readback wrong");

	a_wr_km: assert property (@(posedge ref_clk) disable iff (reset)
		(bus.wr && bus.addr == `SLC_ADDR_KM)
		|=> frames_per_multiframe_minus_one_r == $past(bus.wdata))
		else $error("multiframe length write lost");

	a_wr_ctrl: assert property (@(posedge ref_clk) disable iff (reset)
		(bus.wr && bus.addr == `SLC_ADDR_CTRL)
		|=> link_control_r == $past(bus.wdata))
		else $error("control write lost");

	a_ctrl_stable: assert property (@(posedge ref_clk) disable iff (reset)
		!(bus.wr && bus.addr == `SLC_ADDR_CTRL)
		|=> $stable(link_control_r))
		else $error("control changed without write");

	a_sync_stable: assert property (@(posedge ref_clk) disable iff (reset)
		!(bus.wr && bus.addr == `SLC_ADDR_SYNC)
		|=> $stable(software_sync_request_r))
		else $error("sync bit changed without write");

	// Counts cycles spent disabled; saturates so a long idle never wraps
	logic [3:0] off_count_r;
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			off_count_r <= 4'h0;
		end else if (serial_link_enable_r[0]) begin
			off_count_r <= 4'h0;
		end else if (off_count_r != 4'hF) begin
			off_count_r <= off_count_r + 4'h1;
		end
	end

	a_off_long: assert property (@(posedge ref_clk) disable iff (reset)
		(off_count_r == 4'hF)
		|-> (link_reset && serializer_power_down && link_cfg.lane_mask == 8'h00))
		else $error("long disabled link not held");
endmodule : slc_regs

// ### slc_rx_model.sv
`timescale 1ns/10ps
module slc_rx_model (
	input  wire logic       ref_clk,
	input  wire logic [1:0] hold_low,
	output logic            se_n,
	output logic            ts_n
);
	// Receiver pulls a line low to ask for resync, and changes it only after an edge
	initial begin
		se_n = 1'b1;
		ts_n = 1'b1;
	end
	always @(posedge ref_clk) begin
		se_n <= ~hold_low[0];
		ts_n <= ~hold_low[1];
	end
endmodule : slc_rx_model

// ### testbench.sv
`timescale 1ns/10ps
`include "slc_consts.svh"
module testbench;
	import slc_pkg::*;
	logic          ref_clk = 1'b0;
	logic          reset = 1'b1;
	slc_bus_t      b = '0;
	logic [7:0]    rdata, k_eff, v, km;
	logic [7:0]    f_p = 8'h04;
	logic [1:0]    e_p = 2'h1;
	logic [1:0]    hold = 2'h0;
	logic [3:0]    lanes = 4'h1;
	logic          se_n, ts_n, l_rst, pd, sw, up, m66;
	slc_link_cfg_t cfg;
	integer        seed = 32'ha505;
	int            err_total = 0;
	int            check_count = 0;
	always #50 ref_clk = ~ref_clk;
	slc_rx_model i_rx (.ref_clk(ref_clk), .hold_low(hold), .se_n(se_n), .ts_n(ts_n));
	slc_regs i_dut (.ref_clk(ref_clk), .reset(reset), .bus(b), .rdata(rdata),
		.single_ended_sync_input_n(se_n), .differential_timestamp_input_n(ts_n),
		.e_param(e_p), .f_param(f_p), .lane_count(lanes), .link_cfg(cfg),
		.k_effective(k_eff), .link_reset(l_rst), .serializer_power_down(pd));
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		b <= '{a, d, 1'b1, 1'b0};
		@(posedge ref_clk);
		b.wr <= 1'b0;
	endtask : wr
	task wr_rd(input logic [11:0] a, input logic [7:0] d, input string n);
		@(posedge ref_clk);
		b <= '{a, d, 1'b1, 1'b0};
		@(posedge ref_clk);
		b <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge ref_clk);
		b.rd <= 1'b0;
		#1 chk(n, d, rdata);
	endtask : wr_rd
	task rd(input logic [11:0] a, input logic [7:0] e, input string n);
		@(posedge ref_clk);
		b <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge ref_clk);
		b.rd <= 1'b0;
		#1 chk(n, e, rdata);
	endtask : rd
	task settle;
		repeat (5) @(posedge ref_clk);
		#1;
	endtask : settle
	task give_verdict;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : give_verdict
	function automatic logic exp_sync(input logic [1:0] s, input logic w, input logic [1:0] h);
		return !w || (s == `SLC_SEL_SE && h[0]) || (s == `SLC_SEL_TS && h[1]);
	endfunction : exp_sync
	// Writable bits per register, reserved bits kept at their reset value
	function automatic logic [7:0] wmask(input logic [1:0] r);
		case (r)
			2'h0: return 8'hFF;
			2'h1: return 8'h01;
			default: return 8'h1F;
		endcase
	endfunction : wmask
	function automatic logic [7:0] exp_mask(input logic [3:0] l, input logic u);
		logic [7:0] f;
		f = (8'h01 << l) - 8'h01;
		return u ? f << 4 : f;
	endfunction : exp_mask
	function automatic logic [7:0] exp_k(input logic m, input int e, input int f, input logic [7:0] k);
		return m ? 8'((256 * e) / f - 1) : k;
	endfunction : exp_k
	initial begin
		repeat (5000) @(posedge ref_clk);
		err_total++;
		give_verdict;
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		rd(`SLC_ADDR_ENABLE, `SLC_RST_ENABLE, "enable");
		rd(`SLC_ADDR_KM, `SLC_RST_KM, "km");
		rd(`SLC_ADDR_SYNC, `SLC_RST_SYNC, "sync");
		rd(`SLC_ADDR_CTRL, `SLC_RST_CTRL, "ctrl");
		rd(`SLC_ADDR_TEST, `SLC_RST_TEST, "test");
		rd(12'h206, 8'h00, "unmapped");
		chk("k_eff", `SLC_RST_KM, k_eff);
		chk("scramble", 8'h01, {7'h0, cfg.scramble});
		chk("format", 8'h01, {7'h0, cfg.sample_format});
		$display("test reset values done");
		// Settings only move while the link is off
		wr(`SLC_ADDR_ENABLE, 8'h00);
		settle;
		chk("link_reset", 8'h01, {7'h0, l_rst});
		chk("power_down", 8'h01, {7'h0, pd});
		for (int i = 0; i < 8; i++) begin
			v = 8'($random(seed)) & wmask(2'(i % 4));
			wr_rd(`SLC_ADDR_KM + 12'(i % 4), v, "readback");
		end
		wr(`SLC_ADDR_TEST, 8'h00);
		settle;
		chk("test_sel", 8'h00, {3'h0, cfg.test_select});
		$display("test readback done");
		// Timestamp receiver enable lives outside this block
		for (int i = 0; i < 32; i++) begin
			@(posedge ref_clk) hold <= 2'(i);
			wr(`SLC_ADDR_CTRL, {4'h0, 2'(i >> 3), 2'h3});
			wr(`SLC_ADDR_SYNC, {7'h0, i[2]});
			settle;
			chk("sync_req", {7'h0, exp_sync(2'(i >> 3), i[2], 2'(i))}, {7'h0, cfg.sync_request});
		end
		@(posedge ref_clk) hold <= 2'h0;
		wr(`SLC_ADDR_SYNC, 8'h01);
		$display("test sync source done");
		for (int i = 0; i < 8; i++) begin
			v = 8'($random(seed));
			km = 8'($random(seed));
			up = i[2];
			m66 = i[0];
			@(posedge ref_clk);
			lanes <= 4'(i % 4 + 1);
			e_p <= 2'h1 + 2'(v[7]);
			f_p <= 8'h04 << v[6:5];
			wr(`SLC_ADDR_MODE, {2'h0, m66, 5'h0});
			wr(`SLC_ADDR_KM, km);
			wr(`SLC_ADDR_CTRL, {3'h0, up, 2'h0, v[1:0]});
			wr(`SLC_ADDR_ENABLE, 8'h01);
			settle;
			chk("lane_mask", exp_mask(lanes, up), cfg.lane_mask);
			chk("format", {7'h0, v[1]}, {7'h0, cfg.sample_format});
			chk("scramble", {7'h0, m66 | v[0]}, {7'h0, cfg.scramble});
			chk("k_eff", exp_k(m66, int'(e_p), int'(f_p), km), k_eff);
			chk("k_cfg", exp_k(m66, int'(e_p), int'(f_p), km), cfg.k_minus_one);
			chk("mode", {2'h0, m66, 5'h0}, {2'h0, cfg.mode});
			chk("link_en", 8'h01, {7'h0, cfg.link_enable});
			chk("power_down", 8'h00, {7'h0, pd});
			chk("link_reset", 8'h00, {7'h0, l_rst});
			wr(`SLC_ADDR_ENABLE, 8'h00);
			settle;
			chk("mask_off", 8'h00, cfg.lane_mask);
		end
		$display("test link config done");
		give_verdict;
	end
endmodule : testbench
